// ---- hw/adio_ports.sv ----
// two 8-bit general-purpose ports sharing pins with the external address and data bus
// What this block does
// - direction registers are 8-bit write-only; 1 output, 0 input; reads return all ones
// - all six registers clear on reset and hardware standby, keep through software standby
// - first-port address outputs hold their state on entering software standby
// - mode 1: all first-port pins drive address regardless of direction
// - hardware standby: first-port address outputs go high-impedance
// - modes 2/3 expansion on: direction 1 gives address, 0 input
// - expansion on and strobe select set: first-port pins 7..4 become general outputs
// - pin 7 may carry a supporting-module output; address use takes priority over it on that pin
// - modes 2/3 expansion off: direction 1 gives general or PWM output, 0 input
// - expansion off: pin 7 may also carry the timer blanking output
// - first-port read gives latch for output bits, pin level for input bits
// - modes 2/3: first-port pull-up on when pull-up bit 1 and direction 0
// - first-port pull-ups off in mode 1, reset and hardware standby
// - mode 1 or expansion on: second port is the data bus, direction ignored
// - second port as data bus floats after reset and in both standbys
// - modes 2/3 expansion off: second-port direction 1 drives latch, 0 input
// - second-port read gives latch for outputs, pin level for inputs
// - second-port pull-up only with expansion off, pull-up bit 1, direction 0
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module adio_ports
   import adio_pkg::*;
#(
   parameter int WIDTH = DATA_W
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // register port
   input wire logic [ADDR_W-1:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [7:0] o_reg_rdata,
   // operating state
   input wire logic [1:0] i_mode,
   input wire logic i_external_expansion_enable,
   input wire logic i_io_strobe_select,
   input wire logic i_hw_standby,
   input wire logic i_sw_standby,
   // internal sources for the first port
   input wire logic [7:0] i_addr_hi,
   input wire logic [7:0] i_pwm_en,
   input wire logic [7:0] i_pwm_out,
   input wire logic i_module_pin7_en,
   input wire logic i_module_pin7_out,
   input wire logic i_timer_blanking_en,
   input wire logic i_timer_blanking_output,
   // internal data bus for the second port
   input wire logic i_bus_drive,
   input wire logic [7:0] i_bus_wdata,
   output logic [7:0] o_bus_rdata,
   // first port pins
   input wire logic [7:0] i_first_pin,
   output logic [7:0] o_first_pin,
   output logic [7:0] o_first_pin_oe_n,
   output logic [7:0] o_first_pullup,
   // second port pins
   input wire logic [7:0] i_second_pin,
   output logic [7:0] o_second_pin,
   output logic [7:0] o_second_pin_oe_n,
   output logic [7:0] o_second_pullup
);

   logic [7:0] first_port_pullup_ctrl;
   logic [7:0] second_port_pullup_ctrl;
   logic [7:0] first_port_direction;
   logic [7:0] first_port_output_latch;
   logic [7:0] second_port_direction;
   logic [7:0] second_port_output_latch;
   logic [7:0] first_level;
   logic [7:0] second_level;

   // decode
   wire clr_regs = i_rst | i_hw_standby;
   wire mode1 = (i_mode == ADIO_MODE_1);
   wire mode23 = (i_mode == ADIO_MODE_2) | (i_mode == ADIO_MODE_3);
   wire expand = mode23 & i_external_expansion_enable;
   wire single = mode23 & ~i_external_expansion_enable;
   wire data_bus = mode1 | expand;
   wire wr_regs = i_reg_wr & ~i_sw_standby;
   wire sel_fpu = (i_reg_addr == ADDR_FIRST_PULLUP);
   wire sel_spu = (i_reg_addr == ADDR_SECOND_PULLUP);
   wire sel_fdir = (i_reg_addr == ADDR_FIRST_DIR);
   wire sel_flat = (i_reg_addr == ADDR_FIRST_LATCH);
   wire sel_sdir = (i_reg_addr == ADDR_SECOND_DIR);
   wire sel_slat = (i_reg_addr == ADDR_SECOND_LATCH);

   // per-register write enables; writes are dropped in software standby
   wire wr_fpu = wr_regs & sel_fpu;
   wire wr_spu = wr_regs & sel_spu;
   wire wr_fdir = wr_regs & sel_fdir;
   wire wr_flat = wr_regs & sel_flat;
   wire wr_sdir = wr_regs & sel_sdir;
   wire wr_slat = wr_regs & sel_slat;

   // three-stage pin synchronisers for the first port, one slice per bit
   // a change is taken only once stages two and three agree, so one late sample cannot glitch a read
   genvar s;
   generate
      for (s = 0; s < WIDTH; s = s + 1) begin : g_sync_first
         logic stage1;
         logic stage2;
         logic stage3;
         logic level;
         always_ff @(posedge i_clk_sys) begin
            stage1 <= i_first_pin[s];
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
               level <= stage2;
            end
         end
         assign first_level[s] = level;
      end
   endgenerate

   // three-stage pin synchronisers for the second port, one slice per bit
   genvar t;
   generate
      for (t = 0; t < WIDTH; t = t + 1) begin : g_sync_second
         logic stage1;
         logic stage2;
         logic stage3;
         logic level;
         always_ff @(posedge i_clk_sys) begin
            stage1 <= i_second_pin[t];
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
               level <= stage2;
            end
         end
         assign second_level[t] = level;
      end
   endgenerate

   // registers: cleared by reset and hardware standby, frozen in software standby
   // first port pull-up control
   always_ff @(posedge i_clk_sys) begin
      if (clr_regs) begin
         first_port_pullup_ctrl <= REG_RESET;
      end else if (wr_fpu) begin
         first_port_pullup_ctrl <= i_reg_wdata;
      end
   end

   // second port pull-up control
   always_ff @(posedge i_clk_sys) begin
      if (clr_regs) begin
         second_port_pullup_ctrl <= REG_RESET;
      end else if (wr_spu) begin
         second_port_pullup_ctrl <= i_reg_wdata;
      end
   end

   // first port direction, write-only
   always_ff @(posedge i_clk_sys) begin
      if (clr_regs) begin
         first_port_direction <= REG_RESET;
      end else if (wr_fdir) begin
         first_port_direction <= i_reg_wdata;
      end
   end

   // first port output latch, stored whatever the direction
   always_ff @(posedge i_clk_sys) begin
      if (clr_regs) begin
         first_port_output_latch <= REG_RESET;
      end else if (wr_flat) begin
         first_port_output_latch <= i_reg_wdata;
      end
   end

   // second port direction, write-only
   always_ff @(posedge i_clk_sys) begin
      if (clr_regs) begin
         second_port_direction <= REG_RESET;
      end else if (wr_sdir) begin
         second_port_direction <= i_reg_wdata;
      end
   end

   // second port output latch, stored whatever the direction
   always_ff @(posedge i_clk_sys) begin
      if (clr_regs) begin
         second_port_output_latch <= REG_RESET;
      end else if (wr_slat) begin
         second_port_output_latch <= i_reg_wdata;
      end
   end

   // read data: output bits show the latch, input bits the synchronised pin
   wire [7:0] first_read = (first_port_direction & first_port_output_latch)
                         | (~first_port_direction & first_level);
   wire [7:0] second_read = (second_port_direction & second_port_output_latch)
                          | (~second_port_direction & second_level);
   // read selection: each source gated by its own select, so exactly one term is live
   wire rd_dir = sel_fdir | sel_sdir;
   wire rd_none = ~(sel_fpu | sel_spu | rd_dir | sel_flat | sel_slat);
   wire [7:0] rd_mux = ({8{sel_fpu}} & first_port_pullup_ctrl)
                     | ({8{sel_spu}} & second_port_pullup_ctrl)
                     | ({8{rd_dir}} & RD_WRITE_ONLY)
                     | ({8{sel_flat}} & first_read)
                     | ({8{sel_slat}} & second_read)
                     | ({8{rd_none}} & RD_UNMAPPED);
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_reg_rdata <= REG_RESET;
      end else if (i_reg_rd) begin
         o_reg_rdata <= rd_mux;
      end
   end

   // first port pin functions, one slice per bit
   logic [7:0] next_first_pin;
   logic [7:0] next_first_oe_n;
   logic [7:0] next_first_pullup;
   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_first
         wire is_hi = (g >= IO_STROBE_SELECT_LO);
         wire is_p7 = (g == PIN7);
         wire dir = first_port_direction[g];
         // strobe select hands pins 7..4 back to the general output path
         wire io_strobe_select_free = i_io_strobe_select & is_hi;
         // address use: always in mode 1, else with expansion on for output bits unless strobe select frees them
         wire addr_use = mode1 | (expand & dir & ~io_strobe_select_free);
         wire mod7 = is_p7 & i_module_pin7_en & ~addr_use;
         wire blank7 = is_p7 & single & i_timer_blanking_en;
         wire drive = addr_use | mod7 | blank7 | (mode23 & dir);
         wire gen_val = i_pwm_en[g] ? i_pwm_out[g] : first_port_output_latch[g];
         wire val = addr_use ? i_addr_hi[g] :
                    mod7 ? i_module_pin7_out :
                    blank7 ? i_timer_blanking_output :
                    gen_val;
         assign next_first_pin[g] = val;
         assign next_first_oe_n[g] = ~drive;
         assign next_first_pullup[g] = mode23 & first_port_pullup_ctrl[g] & ~dir;
      end
   endgenerate

   // second port: data bus or general port, one slice per bit
   logic [7:0] next_second_pin;
   logic [7:0] next_second_oe_n;
   logic [7:0] next_second_pullup;
   // the data bus only drives while the core writes and the clock runs
   wire bus_out = i_bus_drive & ~i_sw_standby;
   genvar h;
   generate
      for (h = 0; h < WIDTH; h = h + 1) begin : g_second
         wire dir = second_port_direction[h];
         wire drive = data_bus ? bus_out : dir;
         wire val = data_bus ? i_bus_wdata[h] : second_port_output_latch[h];
         assign next_second_pin[h] = val;
         assign next_second_oe_n[h] = ~drive;
         assign next_second_pullup[h] = single & second_port_pullup_ctrl[h] & ~dir;
      end
   endgenerate

   // first port pin values; software standby freezes the driven state
   always_ff @(posedge i_clk_sys) begin
      if (clr_regs) begin
         o_first_pin <= REG_RESET;
      end else if (!i_sw_standby) begin
         o_first_pin <= next_first_pin;
      end
   end

   // first port enables; all released in reset and hardware standby
   always_ff @(posedge i_clk_sys) begin
      if (clr_regs) begin
         o_first_pin_oe_n <= ~REG_RESET;
      end else if (!i_sw_standby) begin
         o_first_pin_oe_n <= next_first_oe_n;
      end
   end

   // first port pull-ups; they keep following the retained registers in software standby
   always_ff @(posedge i_clk_sys) begin
      if (clr_regs) begin
         o_first_pullup <= REG_RESET;
      end else begin
         o_first_pullup <= next_first_pullup;
      end
   end

   // second port pin values
   always_ff @(posedge i_clk_sys) begin
      if (clr_regs) begin
         o_second_pin <= REG_RESET;
      end else begin
         o_second_pin <= next_second_pin;
      end
   end

   // second port enables
   always_ff @(posedge i_clk_sys) begin
      if (clr_regs) begin
         o_second_pin_oe_n <= ~REG_RESET;
      end else begin
         o_second_pin_oe_n <= next_second_oe_n;
      end
   end

   // second port pull-ups
   always_ff @(posedge i_clk_sys) begin
      if (clr_regs) begin
         o_second_pullup <= REG_RESET;
      end else begin
         o_second_pullup <= next_second_pullup;
      end
   end

   // synchronised second-port level for the core's data-bus reads
   always_ff @(posedge i_clk_sys) begin
      if (clr_regs) begin
         o_bus_rdata <= REG_RESET;
      end else begin
         o_bus_rdata <= second_level;
      end
   end

endmodule

// ---- hw/adio_pkg.sv ----
// constants for the address/data general-purpose port block
package adio_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam logic [15:0] ADDR_FIRST_PULLUP = 16'hFFAD;
   localparam logic [15:0] ADDR_SECOND_PULLUP = 16'hFFAE;
   localparam logic [15:0] ADDR_FIRST_DIR = 16'hFFB1;
   localparam logic [15:0] ADDR_FIRST_LATCH = 16'hFFB3;
   localparam logic [15:0] ADDR_SECOND_DIR = 16'hFFB4;
   localparam logic [15:0] ADDR_SECOND_LATCH = 16'hFFB6;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;
   // value returned for a read of a write-only direction register
   localparam logic [7:0] RD_WRITE_ONLY = 8'hFF;
   localparam int PIN7 = 7;
   localparam int IO_STROBE_SELECT_LO = 4;
   typedef enum logic [1:0] {
      ADIO_MODE_RSVD = 2'b00,
      ADIO_MODE_1 = 2'b01,
      ADIO_MODE_2 = 2'b10,
      ADIO_MODE_3 = 2'b11
   } adio_mode_e;
endpackage

// ---- sim/adio_ports_assertions.sv ----
// concurrent checks on the port block pins and register port
`timescale 1ns/1ps
module adio_ports_assertions
   import adio_pkg::*;
(
   // block inputs
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [15:0] i_reg_addr,
   input wire logic i_reg_rd,
   input wire logic [1:0] i_mode,
   input wire logic i_external_expansion_enable,
   input wire logic i_hw_standby,
   input wire logic i_sw_standby,
   input wire logic [7:0] i_addr_hi,
   input wire logic i_bus_drive,
   input wire logic [7:0] i_bus_wdata,
   // block outputs
   input wire logic [7:0] o_reg_rdata,
   input wire logic [7:0] o_first_pin,
   input wire logic [7:0] o_first_pin_oe_n,
   input wire logic [7:0] o_first_pullup,
   input wire logic [7:0] o_second_pin,
   input wire logic [7:0] o_second_pin_oe_n,
   input wire logic [7:0] o_second_pullup
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   wire logic m1 = i_mode == ADIO_MODE_1;
   wire logic up = !i_hw_standby && !i_sw_standby;
   wire logic dr = i_reg_addr == ADDR_FIRST_DIR || i_reg_addr == ADDR_SECOND_DIR;
   dir_read_a: assert property (i_reg_rd && dr |=> o_reg_rdata == RD_WRITE_ONLY) else $error("bad read");
   hw_float_a: assert property (i_hw_standby |=> (o_first_pin_oe_n & o_second_pin_oe_n) == 8'hFF)
      else $error("not floated");
   mode1_addr_a: assert property (m1 && up |=> o_first_pin_oe_n == 8'h00 && o_first_pin == $past(i_addr_hi))
      else $error("no address");
   mode1_pull_a: assert property (m1 |=> o_first_pullup == 8'h00) else $error("pull-up on");
   sw_hold_a: assert property (i_sw_standby && !i_hw_standby |=> $stable(o_first_pin) && $stable(o_first_pin_oe_n))
      else $error("pins moved");
   bus_drive_a: assert property (m1 && up && i_bus_drive
      |=> o_second_pin_oe_n == 8'h00 && o_second_pin == $past(i_bus_wdata)) else $error("bus not driven");
   bus_float_a: assert property (m1 && !i_bus_drive |=> o_second_pin_oe_n == 8'hFF) else $error("bus driven");
   exp_pull_a: assert property (i_external_expansion_enable || m1 |=> o_second_pullup == 8'h00)
      else $error("pull-up on");
endmodule

// ---- sim/adio_pin_model.sv ----
// board side of one port: a driver that takes every line the device releases
`timescale 1ns/1ps
module adio_pin_model (
   // device side
   input wire logic [7:0] i_pin,
   input wire logic [7:0] i_oe_n,
   // board side
   input wire logic [7:0] i_ext,
   output logic [7:0] o_level
);
   assign o_level = (~i_oe_n & i_pin) | (i_oe_n & i_ext);
endmodule

// ---- sim/address_data_io_ports_tb_top.sv ----
// self-checking bench for the address/data port block
`timescale 1ns/1ps
module address_data_io_ports_tb_top import adio_pkg::*;;
   logic i_clk_sys = 1'b0, i_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_hw_standby = 1'b0, i_sw_standby = 1'b0;
   logic i_external_expansion_enable = 1'b0, i_io_strobe_select = 1'b0, i_bus_drive = 1'b0, i_module_pin7_en = 1'b0;
   logic i_module_pin7_out = 1'b1, i_timer_blanking_en = 1'b0, i_timer_blanking_output = 1'b0, rd_d = 1'b0, look = 1'b0;
   logic [1:0] i_mode = ADIO_MODE_2;
   logic [15:0] i_reg_addr = 16'h0000;
   logic [7:0] i_reg_wdata = 8'h00, i_addr_hi = 8'h00, i_pwm_en = 8'h00, i_pwm_out = 8'h00, i_bus_wdata = 8'h00;
   logic [7:0] ext1 = 8'h00, ext2 = 8'h00, r, l, d;
   logic [18:0] q[$];
   logic [18:0] e;
   int n_fail = 0;
   int n_compared = 0;
   wire logic [7:0] o_reg_rdata, o_bus_rdata, i_first_pin, o_first_pin, o_first_pin_oe_n, o_first_pullup;
   wire logic [7:0] i_second_pin, o_second_pin, o_second_pin_oe_n, o_second_pullup;
   wire logic [63:0] ov = {o_bus_rdata, o_second_pin_oe_n, o_second_pullup, o_first_pullup, o_second_pin,
      o_first_pin_oe_n,
      o_first_pin, o_reg_rdata};
   adio_ports dut (.*);
   adio_pin_model b1 (.i_pin(o_first_pin), .i_oe_n(o_first_pin_oe_n), .i_ext(ext1), .o_level(i_first_pin));
   adio_pin_model b2 (.i_pin(o_second_pin), .i_oe_n(o_second_pin_oe_n), .i_ext(ext2), .o_level(i_second_pin));
   always #50 i_clk_sys = ~i_clk_sys;
   always @(posedge i_clk_sys) rd_d <= i_reg_rd;
   // oldest note: output select, bit mask, expected value
   always @(negedge i_clk_sys) begin
      if (rd_d || look) begin
         e = q.pop_front();
         n_compared++;
         if ((ov[e[18:16]*8 +: 8] & e[15:8]) !== (e[7:0] & e[15:8])) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, ov[e[18:16]*8 +: 8] & e[15:8], e[7:0] & e[15:8]);
         end
      end
   end
   // strobes stay up between back-to-back accesses; obs drops them
   task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] v);
      i_reg_addr <= a;
      i_reg_wdata <= v;
      i_reg_wr <= w;
      i_reg_rd <= !w;
      if (!w) q.push_back({3'd0, 8'hFF, v});
      @(posedge i_clk_sys);
   endtask
   task automatic obs(input logic [2:0] s, input logic [7:0] m, input logic [7:0] v);
      i_reg_wr <= 1'b0;
      i_reg_rd <= 1'b0;
      repeat (5) @(posedge i_clk_sys);
      q.push_back({s, m, v});
      look <= 1'b1;
      @(posedge i_clk_sys);
      look <= 1'b0;
   endtask
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      void'($urandom(32'h8398));
      r = $urandom();
      ext1 = $urandom();
      ext2 = $urandom();
      i_addr_hi = $urandom();
      i_bus_wdata = $urandom();
      repeat (2) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      acc(0, ADDR_FIRST_PULLUP, REG_RESET);
      acc(0, ADDR_SECOND_DIR, RD_WRITE_ONLY);
      acc(0, 16'hFFB2, RD_UNMAPPED);
      obs(7, 8'hFF, ext2);
      for (int p = 0; p < 2; p++) begin
         l = $urandom();
         d = $urandom();
         acc(1, p ? ADDR_SECOND_LATCH : ADDR_FIRST_LATCH, l);
         acc(1, p ? ADDR_SECOND_DIR : ADDR_FIRST_DIR, d);
         acc(1, p ? ADDR_SECOND_PULLUP : ADDR_FIRST_PULLUP, r);
         obs(p ? 3'd3 : 3'd1, d, l);
         obs(p ? 3'd6 : 3'd2, 8'hFF, ~d);
         acc(0, p ? ADDR_SECOND_LATCH : ADDR_FIRST_LATCH, (d & l) | (~d & (p ? ext2 : ext1)));
         acc(0, p ? ADDR_SECOND_PULLUP : ADDR_FIRST_PULLUP, r);
         obs(p ? 3'd5 : 3'd4, 8'hFF, r & ~d);
      end
      acc(1, ADDR_FIRST_DIR, 8'h00);
      i_module_pin7_en <= 1'b1;
      obs(1, 8'h80, 8'h80);
      obs(2, 8'h80, 8'h00);
      i_module_pin7_en <= 1'b0;
      i_timer_blanking_en <= 1'b1;
      i_timer_blanking_output <= 1'b1;
      obs(1, 8'h80, 8'h80);
      obs(2, 8'h80, 8'h00);
      i_timer_blanking_en <= 1'b0;
      acc(1, ADDR_FIRST_DIR, 8'hFF);
      acc(1, ADDR_FIRST_LATCH, r);
      i_pwm_en <= 8'h0F;
      i_pwm_out <= ~r;
      obs(1, 8'hFF, {r[7:4], ~r[3:0]});
      i_external_expansion_enable <= 1'b1;
      obs(1, 8'hFF, i_addr_hi);
      i_io_strobe_select <= 1'b1;
      obs(1, 8'hFF, {r[7:4], i_addr_hi[3:0]});
      i_mode <= ADIO_MODE_1;
      i_bus_drive <= 1'b1;
      obs(3, 8'hFF, i_bus_wdata);
      i_bus_drive <= 1'b0;
      obs(6, 8'hFF, 8'hFF);
      i_mode <= ADIO_MODE_3;
      i_sw_standby <= 1'b1;
      acc(1, ADDR_FIRST_PULLUP, ~r);
      acc(0, ADDR_FIRST_PULLUP, r);
      i_hw_standby <= 1'b1;
      obs(2, 8'hFF, 8'hFF);
      i_hw_standby <= 1'b0;
      i_sw_standby <= 1'b0;
      acc(0, ADDR_FIRST_PULLUP, REG_RESET);
      obs(4, 8'hFF, 8'h00);
      report_and_stop();
   end
endmodule
bind adio_ports adio_ports_assertions chk (.*);
